// *** core/gpc_pkg.sv ***
// Package for the general-purpose port pin control block.
// Assumes a plain register port with byte-wide data and one system clock.
package gpc_pkg;
   // Register offsets on the register port.
   localparam logic [3:0] ADDR_PIN_INPUT     = 4'h0;
   localparam logic [3:0] ADDR_DIRECTION     = 4'h1;
   localparam logic [3:0] ADDR_OUTPUT_LATCH  = 4'h2;
   localparam logic [3:0] ADDR_PWR_PIN_CTRL  = 4'h3;
   localparam logic [3:0] ADDR_ALT_ENABLE    = 4'h4;
   // Field position of the global pull-up disable in the control register.
   localparam int         PUD_BIT            = 6;
   // Reset values.
   localparam logic [7:0] RST_CONTROL        = 8'h00;
   localparam logic [7:0] RST_DATA           = 8'h00;
   // One-hot pin mode codes, one bit per {direction, latch} combination.
   typedef enum logic [3:0] {
      GPC_MODE_TRISTATE = 4'b0001,
      GPC_MODE_PULLUP   = 4'b0010,
      GPC_MODE_OUT_LOW  = 4'b0100,
      GPC_MODE_OUT_HIGH = 4'b1000
   } gpc_mode_t;
endpackage : gpc_pkg

// *** core/gpc_pin_if.sv ***
// Interface carrying per-pin control bits from the register file to the pad logic.
// Assumes one instance per port, all pins in one vector.
`timescale 1ns/1ps
interface gpc_pin_if #(parameter int WIDTH = 6);
   logic [WIDTH-1:0] direction;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] alt_en;
   logic [WIDTH-1:0] alt_val;
   logic             global_pullup_disable;
   modport ctrl (output direction, output latch, output alt_en, output alt_val, output global_pullup_disable);
   modport pad  (input direction, input latch, input alt_en, input alt_val, input global_pullup_disable);
endinterface : gpc_pin_if

// *** core/gpc_pad.sv ***
// Pad logic: turns direction, latch and pull-up disable into pin drive signals.
// Assumes the asynchronous reset tri-states the pins with no clock running.
`timescale 1ns/1ps
module gpc_pad #(
   parameter int WIDTH = 6
) (
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // Control from the register file.
   gpc_pin_if.pad                pins,
   // Pin drive.
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] pin_pullup
);
   // Drive registers; reset clears them at once so pins float without a clock.
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            pin_oe[i]     <= 1'b0;
            pin_out[i]    <= 1'b0;
            pin_pullup[i] <= 1'b0;
         end else if (clk_en) begin
            pin_oe[i]     <= pins.direction[i];
            // Compare output reaches the pin only through an output direction.
            pin_out[i]    <= pins.direction[i] &
                             (pins.alt_en[i] ? pins.alt_val[i] : pins.latch[i]);
            pin_pullup[i] <= ~pins.direction[i] & pins.latch[i] & ~pins.global_pullup_disable;
         end
      end
   end
endmodule : gpc_pad

// *** core/gpc_port.sv ***
// Top of the port pin control block: register file, input synchroniser, pad logic.
// Assumes a plain register port and pin inputs asynchronous to clk_sys.
//
// Functional notes
// - Direction one makes output, zero input.
// - Input with latch one gets pull-up.
// - Pull-up off when latch zero or output.
// - Reset tri-states all pins without clock.
// - Output drives latch value onto pin, or compare output when alt enable set.
// - Writing one to pin-input toggles latch.
// - Global disable turns off all pull-ups.
// - Compare output only reaches output pins.
`timescale 1ns/1ps
module gpc_port #(
   parameter int WIDTH = 6
) (
   // Clock, reset and enable.
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // Register port.
   input  wire logic [3:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // Timer compare outputs.
   input  wire logic [WIDTH-1:0] timer_compare_output,
   // Pins.
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] pin_pullup
);
   // Port pins sit in the low bits of a byte register.
   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("gpc_port: WIDTH must be 1 to 8");
   end

   gpc_pin_if #(.WIDTH(WIDTH)) pins ();

   logic [WIDTH-1:0] direction_register_r;
   logic [WIDTH-1:0] output_latch_register_r;
   logic [WIDTH-1:0] alt_enable_r;
   logic [7:0]       power_and_pin_control_r;
   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] pin_input_register_r;
   logic [7:0]       rdata_nxt;
   logic [WIDTH-1:0] wd;

   assign wd = reg_wdata[WIDTH-1:0];

   // Direction register; reset leaves every pin an input.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         direction_register_r <= '0;
      end else if (clk_en && reg_wr && reg_addr == gpc_pkg::ADDR_DIRECTION) begin
         direction_register_r <= wd;
      end
   end

   // Output latch; a one written to the pin-input address flips the latch bit.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         output_latch_register_r <= '0;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == gpc_pkg::ADDR_OUTPUT_LATCH) begin
            output_latch_register_r <= wd;
         end else if (reg_addr == gpc_pkg::ADDR_PIN_INPUT) begin
            output_latch_register_r <= output_latch_register_r ^ wd;
         end
      end
   end

   // Control register; only the pull-up disable acts here, the rest is storage.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         power_and_pin_control_r <= gpc_pkg::RST_CONTROL;
      end else if (clk_en && reg_wr && reg_addr == gpc_pkg::ADDR_PWR_PIN_CTRL) begin
         power_and_pin_control_r <= reg_wdata;
      end
   end

   // Alternate-function enables select the compare output per pin.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         alt_enable_r <= '0;
      end else if (clk_en && reg_wr && reg_addr == gpc_pkg::ADDR_ALT_ENABLE) begin
         alt_enable_r <= wd;
      end
   end

   // Two-stage synchroniser; only the second stage is ever read.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r              <= '0;
         pin_input_register_r <= '0;
      end else if (clk_en) begin
         sync1_r              <= pin_in;
         pin_input_register_r <= sync1_r;
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      rdata_nxt = gpc_pkg::RST_DATA;
      unique case (reg_addr)
         gpc_pkg::ADDR_PIN_INPUT:    rdata_nxt[WIDTH-1:0] = pin_input_register_r;
         gpc_pkg::ADDR_DIRECTION:    rdata_nxt[WIDTH-1:0] = direction_register_r;
         gpc_pkg::ADDR_OUTPUT_LATCH: rdata_nxt[WIDTH-1:0] = output_latch_register_r;
         gpc_pkg::ADDR_PWR_PIN_CTRL: rdata_nxt = power_and_pin_control_r;
         gpc_pkg::ADDR_ALT_ENABLE:   rdata_nxt[WIDTH-1:0] = alt_enable_r;
         default:                    rdata_nxt = gpc_pkg::RST_DATA;
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= gpc_pkg::RST_DATA;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_nxt : gpc_pkg::RST_DATA;
      end
   end

   assign pins.direction = direction_register_r;
   assign pins.latch     = output_latch_register_r;
   assign pins.alt_en    = alt_enable_r;
   assign pins.alt_val   = timer_compare_output;
   assign pins.global_pullup_disable       = power_and_pin_control_r[gpc_pkg::PUD_BIT];

   // Glitch-free mode changes are left to software stepping through safe states.
   gpc_pad #(.WIDTH(WIDTH)) u_pad (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .pins       (pins.pad),
      .pin_out    (pin_out),
      .pin_oe     (pin_oe),
      .pin_pullup (pin_pullup)
   );
endmodule : gpc_port

// *** tb/gpc_props.sv ***
// Checker on the top ports of the port pin block.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module gpc_props #(parameter int WIDTH = 6) (
   // Clock, reset and register port.
   input wire logic             clk_sys,
   input wire logic             rst_b,
   input wire logic             clk_en,
   input wire logic [3:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   // Pins.
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic [WIDTH-1:0] pin_pullup
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Pins settle two edges after a lone write, so the checks look one edge further on.
   property p_dir; (clk_en && reg_wr && reg_addr == 4'h1) ##1 !reg_wr
      |=> ##1 pin_oe == $past(reg_wdata[WIDTH-1:0], 3); endproperty
   a_dir: assert property (p_dir) else $error("enable differs from direction");
   property p_lat; (clk_en && reg_wr && reg_addr == 4'h2) ##1 !reg_wr
      |=> ##1 (pin_pullup & ~$past(reg_wdata[WIDTH-1:0], 3)) == '0; endproperty
   a_lat: assert property (p_lat) else $error("pull-up on a zero latch");
   property p_pud; (clk_en && reg_wr && reg_addr == 4'h3 && reg_wdata[6]) ##1 !reg_wr
      |=> ##1 pin_pullup == '0; endproperty
   a_pud: assert property (p_pud) else $error("pull-up despite disable");
   property p_excl; (pin_pullup & pin_oe) == '0; endproperty
   a_excl: assert property (p_excl) else $error("pull-up on a driven pin");
   property p_out; (pin_out & ~pin_oe) == '0; endproperty
   a_out: assert property (p_out) else $error("drive value while not driving");
   property p_rst; disable iff (1'b0) !rst_b |-> {pin_oe, pin_out, pin_pullup} == '0; endproperty
   a_rst: assert property (p_rst) else $error("pins not released in reset");
   property p_rel; $rose(rst_b) |-> {pin_oe, pin_pullup} == '0; endproperty
   a_rel: assert property (p_rel) else $error("pins active after reset");
   property p_pin; clk_en && reg_rd && reg_addr == 4'h0 && $stable(pin_in)
      && pin_in == $past(pin_in, 2) |=> reg_rdata[WIDTH-1:0] == $past(pin_in); endproperty
   a_pin: assert property (p_pin) else $error("pin read wrong");
endmodule : gpc_props
bind gpc_port gpc_props #(.WIDTH(WIDTH)) u_props (.clk_sys(clk_sys), .rst_b(rst_b),
   .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .pin_pullup(pin_pullup));

// *** tb/gpc_board.sv ***
// Board model: the level each pin takes from all its drivers.
// Assumes a pin nobody drives or pulls flips every cycle.
`timescale 1ns/1ps
module gpc_board (
   // Clock, block side and external source.
   input  wire logic       clk_sys,
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] pin_pullup,
   input  wire logic       ext_en,
   input  wire logic [5:0] ext_val,
   output logic      [5:0] pin_in
);
   logic flt_r = 1'b0;
   // Noise on a floating pin, so it never looks like a held level.
   always_ff @(posedge clk_sys) flt_r <= ~flt_r;
   // Block drive wins, then the source, then the pull-up.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_en ? ext_val : (pin_pullup | {6{flt_r}})));
endmodule : gpc_board

// *** tb/test_gpc_port.sv ***
// Bench for the port pin block with a board model on the pins.
// Assumes the register map and two-edge pin timing of the block.
`timescale 1ns/1ps
module test_gpc_port;
   logic        clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ext_en = 0, clk_en = 1;
   logic [3:0]  reg_addr = '0;
   logic [7:0]  reg_wdata = '0, reg_rdata;
   logic [5:0]  tco = '0, ext_val = '0, pin_in, pin_out, pin_oe, pin_pullup;
   int          err_total = 0, n_tests = 0;
   gpc_port #(.WIDTH(6)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_compare_output(tco), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
   gpc_board u_board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   // A 40 MHz clock.
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // A write waits two more edges so the pins have settled on return.
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [7:0] exp);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", {10'h0, reg_rdata}, {10'h0, exp});
   endtask : rd
   task automatic pins(logic [17:0] exp);
      check("oe_out_pullup", {pin_oe, pin_out, pin_pullup}, exp);
   endtask : pins
   task automatic give_verdict;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   // Modes are walked one register change at a time, as software must.
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(4'h1, 8'h00);
      rd(4'hF, 8'h00);
      pins({6'h00, 6'h00, 6'h00});
      wr(4'h2, 8'h3F);
      pins({6'h00, 6'h00, 6'h3F});
      wr(4'h3, 8'h40);
      pins({6'h00, 6'h00, 6'h00});
      rd(4'h3, 8'h40);
      wr(4'h3, 8'h00);
      wr(4'h1, 8'h3F);
      pins({6'h3F, 6'h3F, 6'h00});
      wr(4'h0, 8'h05);
      pins({6'h3F, 6'h3A, 6'h00});
      rd(4'h0, 8'h3A);
      wr(4'h2, 8'h00);
      pins({6'h3F, 6'h00, 6'h00});
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h03);
      rd(4'h2, 8'h03);
      pins({6'h00, 6'h00, 6'h03});
      {ext_val, ext_en} <= {6'h2A, 1'b1};
      wr(4'h2, 8'h00);
      rd(4'h0, 8'h2A);
      {tco, ext_en} <= {6'h15, 1'b0};
      wr(4'h4, 8'h3F);
      pins({6'h00, 6'h00, 6'h00});
      wr(4'h1, 8'h3F);
      pins({6'h3F, 6'h15, 6'h00});
      // With the enable low a write and a read must leave every register untouched.
      clk_en <= 1'b0;
      wr(4'h1, 8'h00);
      pins({6'h3F, 6'h15, 6'h00});
      rd(4'h1, 8'h00);
      clk_en <= 1'b1;
      rd(4'h1, 8'h3F);
      @(posedge clk_sys);
      #1 check("reg_rdata_idle", {10'h0, reg_rdata}, 18'h0);
      #5 rst_b = 1'b0;
      #1 pins({6'h00, 6'h00, 6'h00});
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(4'h2, 8'h00);
      give_verdict();
   end
   // A hang is cut short well beyond the roughly ninety cycles the run needs.
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end
endmodule : test_gpc_port
